// file: dbsr_engine.v
// shared-bus dma engine with repeat and burst-block modes and debug halt gating
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dbsr_defines.vh"

// How it works
// - in repeat mode, reload size at completion and restart unless enable cleared
// - burst-block mode starts dma units in eight of every ten cycles only, none in the two cpu slots
// - drop bus request within three cycles after a transfer unless another pends
// - debug halt granted only when neither dma nor cpu requests the bus
// - source and destination addresses are 20 bits, writable as one quantity
// - a word write to an address register loads 16 bits, upper bits zero
module dbsr_engine (
	// clock and reset
	input  wire        core_clk,
	input  wire        resetn,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [19:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [19:0] reg_rdata,
	// trigger from a peripheral (asynchronous)
	input  wire        dma_trigger,
	// shared system bus
	input  wire        cpu_bus_req,
	input  wire        cpu_rmw_active,
	input  wire        bus_wait,
	output reg         dma_bus_req,
	output reg         bus_valid,
	output reg         bus_write,
	output reg  [19:0] bus_addr,
	input  wire [15:0] bus_rdata,
	output reg  [15:0] bus_wdata,
	// debug halt
	input  wire        halt_request,
	output reg         halt_granted,
	output reg         halt_pending,
	// status
	output reg         xfer_done
);

	// ----------------------------------------
	// state codes
	// ----------------------------------------
	// a unit walks idle, read, write and gap, then back to idle
	localparam [1:0] ST_IDLE  = 2'd0;
	localparam [1:0] ST_READ  = 2'd1;
	localparam [1:0] ST_WRITE = 2'd2;
	localparam [1:0] ST_GAP   = 2'd3;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// chan_* hold what software programmed, cur_* and size_count the working copy
	reg [4:0]  chan_ctrl;
	reg [19:0] chan_source_address;
	reg [19:0] chan_dest_address;
	reg [15:0] chan_transfer_size;
	reg [15:0] size_count;
	reg [19:0] cur_src;
	reg [19:0] cur_dst;
	reg [15:0] data_hold;
	reg [1:0]  state;
	reg [1:0]  release_count;
	reg [3:0]  win_count;
	reg        trig_meta;
	reg        trig_sync;
	reg        trig_prev;
	reg        pending;
	reg        active;

	wire chan_enable_bit      = chan_ctrl[`DBSR_CTRL_EN];
	wire repeat_mode          = chan_ctrl[`DBSR_CTRL_REPEAT];
	wire burst_mode           = chan_ctrl[`DBSR_CTRL_BURST];
	wire rmw_transfer_inhibit = chan_ctrl[`DBSR_CTRL_RMWDIS];
	wire trig_rise            = trig_sync & ~trig_prev;
	// the start bit is a strobe: it is never stored and reads back as zero
	wire start_wr             = reg_wr && (reg_addr == `DBSR_REG_CTRL) &&
	                            reg_wdata[`DBSR_CTRL_START];

	// burst window: slots 0..7 belong to dma, 8..9 to the cpu
	// no unit starts in a cpu slot, but one started late or slowed by waits can run into them
	wire dma_slot   = ~burst_mode || (win_count < `DBSR_BURST_DMA);
	wire rmw_block  = rmw_transfer_inhibit & cpu_rmw_active;
	wire may_move   = active & chan_enable_bit & dma_slot & ~rmw_block & ~halt_granted;
	// the size counter runs down to one; the unit that sees one is the last
	wire last_unit  = (size_count == 16'h0001);

	// ----------------------------------------
	// trigger synchroniser
	// ----------------------------------------
	// the trigger pin is asynchronous: two flops before the edge detector reads it
	// trig_prev resets low, the idle level of the pin, so reset makes no false edge
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			trig_meta <= 1'b0;
			trig_sync <= 1'b0;
			trig_prev <= 1'b0;
		end else begin
			trig_meta <= dma_trigger;
			trig_sync <= trig_meta;
			trig_prev <= trig_sync;
		end
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// only the programmed values change here; a running block works on its own
	// copies, loaded at block start and at a repeat reload, so a write never bends a move
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			chan_ctrl           <= `DBSR_CTRL_RST;
			chan_source_address <= `DBSR_ADDR_RST;
			chan_dest_address   <= `DBSR_ADDR_RST;
			chan_transfer_size  <= `DBSR_SIZE_RST;
		end else if (reg_wr) begin
			case (reg_addr)
			`DBSR_REG_CTRL:     chan_ctrl <= {1'b0, reg_wdata[3:0]};
			// whole 20-bit quantity in one write, so no transfer can split it
			`DBSR_REG_SRC_LO:   chan_source_address <= reg_wdata;
			`DBSR_REG_DST_LO:   chan_dest_address   <= reg_wdata;
			`DBSR_REG_SRC_HI:   chan_source_address[19:16] <= reg_wdata[3:0];
			`DBSR_REG_DST_HI:   chan_dest_address[19:16]   <= reg_wdata[3:0];
			// word writes clear the top nibble: reach limited to the low 64K
			`DBSR_REG_SRC_WORD: chan_source_address <= {4'h0, reg_wdata[15:0]};
			`DBSR_REG_DST_WORD: chan_dest_address   <= {4'h0, reg_wdata[15:0]};
			`DBSR_REG_SIZE:     chan_transfer_size  <= reg_wdata[15:0];
			default:            chan_ctrl <= chan_ctrl;
			endcase
		end
	end

	// ----------------------------------------
	// register reads, data one cycle later
	// ----------------------------------------
	// zero outside the answer cycle, so a stale word is never taken for an answer
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 20'h0_0000;
		end else if (reg_rd) begin
			case (reg_addr)
			`DBSR_REG_CTRL:     reg_rdata <= {15'h0000, chan_ctrl};
			`DBSR_REG_SRC_LO:   reg_rdata <= chan_source_address;
			`DBSR_REG_SRC_HI:   reg_rdata <= {16'h0000, chan_source_address[19:16]};
			`DBSR_REG_DST_LO:   reg_rdata <= chan_dest_address;
			`DBSR_REG_DST_HI:   reg_rdata <= {16'h0000, chan_dest_address[19:16]};
			`DBSR_REG_SIZE:     reg_rdata <= {4'h0, chan_transfer_size};
			`DBSR_REG_STATUS:   reg_rdata <= {11'h000, halt_granted, pending, active,
			                                  state, size_count[3:0]};
			`DBSR_REG_SRC_WORD: reg_rdata <= {4'h0, chan_source_address[15:0]};
			`DBSR_REG_DST_WORD: reg_rdata <= {4'h0, chan_dest_address[15:0]};
			default:            reg_rdata <= 20'h0_0000;
			endcase
		end else begin
			reg_rdata <= 20'h0_0000;
		end
	end

	// ----------------------------------------
	// transfer engine
	// ----------------------------------------
	// one unit takes four cycles without wait states: the idle cycle that decides, the read, the write
	// and a gap; the gap lets the request and the release count settle before the
	// next decision
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state         <= ST_IDLE;
			active        <= 1'b0;
			pending       <= 1'b0;
			size_count    <= `DBSR_SIZE_RST;
			cur_src       <= `DBSR_ADDR_RST;
			cur_dst       <= `DBSR_ADDR_RST;
			data_hold     <= 16'h0000;
			bus_valid     <= 1'b0;
			bus_write     <= 1'b0;
			bus_addr      <= 20'h0_0000;
			bus_wdata     <= 16'h0000;
			xfer_done     <= 1'b0;
			release_count <= 2'd0;
			win_count     <= 4'h0;
		end else begin
			xfer_done <= 1'b0;
			// trigger seen while busy is remembered; set beats the idle clear below, the enable clear beats the set
			// the idle clear comes in the cycle that would start a block, even with size zero; a low enable clears it in any cycle
			if (trig_rise || start_wr)
				pending <= 1'b1;
			else if (state == ST_IDLE && !active && pending && chan_enable_bit)
				pending <= 1'b0;
			if (!chan_enable_bit)
				pending <= 1'b0;
			// ten-slot window runs only while a burst block moves
			if (active && burst_mode)
				win_count <= (win_count == `DBSR_BURST_WIN - 4'h1) ? 4'h0 : win_count + 4'h1;
			else
				win_count <= 4'h0;
			if (release_count != 2'd0)
				release_count <= release_count - 2'd1;
			case (state)
			ST_IDLE: begin
				bus_valid <= 1'b0;
				if (!active && pending && chan_enable_bit && chan_transfer_size != 16'h0000) begin
					active     <= 1'b1;
					size_count <= chan_transfer_size;
					cur_src    <= chan_source_address;
					cur_dst    <= chan_dest_address;
				end else if (may_move) begin
					bus_valid <= 1'b1;
					bus_write <= 1'b0;
					bus_addr  <= cur_src;
					state     <= ST_READ;
				end else if (active && !chan_enable_bit) begin
					// enable cleared: the block ends in this idle cycle
					active <= 1'b0;
				end
			end
			ST_READ: begin
				// the bus cycle stands for as long as the slave inserts wait states
				if (!bus_wait) begin
					data_hold <= bus_rdata;
					bus_write <= 1'b1;
					bus_addr  <= cur_dst;
					bus_wdata <= bus_rdata;
					state     <= ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (!bus_wait) begin
					bus_valid <= 1'b0;
					bus_write <= 1'b0;
					cur_src   <= cur_src + 20'h0_0001;
					cur_dst   <= cur_dst + 20'h0_0001;
					state     <= ST_GAP;
					if (last_unit) begin
						xfer_done <= 1'b1;
						release_count <= `DBSR_RELEASE_CYC;
						// enable cleared before the end stops the repeat here
						if (repeat_mode && chan_enable_bit) begin
							size_count <= chan_transfer_size;
							cur_src    <= chan_source_address;
							cur_dst    <= chan_dest_address;
						end else begin
							active <= 1'b0;
						end
					end else begin
						size_count <= size_count - 16'h0001;
					end
				end
			end
			ST_GAP: begin
				state <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------
	// bus request and debug halt
	// ----------------------------------------
	// a triggered block asks for the bus as soon as it is pending and keeps asking
	// through the cpu slots of a burst block; no unit starts in those slots, but one
	// started late or slowed by waits can run into them; a halt waits the whole block out unless an rmw inhibit pauses it
	wire work_req         = (active | pending) & chan_enable_bit & ~rmw_block;
	wire cycle_req        = (state == ST_READ) || (state == ST_WRITE);
	wire next_dma_bus_req = work_req || cycle_req;

	// the engine counts as quiet only if it asks neither now nor on the next edge:
	// without the look-ahead a block that starts in this cycle could slip its first
	// bus cycle under a fresh grant
	wire dma_quiet  = ~dma_bus_req & ~next_dma_bus_req;
	wire cpu_quiet  = ~cpu_bus_req;
	// a unit in flight or an open release window also keeps the halt out
	wire unit_quiet = (state == ST_IDLE) && (release_count == 2'd0);
	wire halt_ok    = dma_quiet & cpu_quiet & unit_quiet;

	// ----------------------------------------
	// request and halt registers
	// ----------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dma_bus_req  <= 1'b0;
			halt_granted <= 1'b0;
			halt_pending <= 1'b0;
		end else begin
			dma_bus_req <= next_dma_bus_req;
			if (!halt_request) begin
				// dropping the halt request frees the engine on the next edge
				halt_granted <= 1'b0;
				halt_pending <= 1'b0;
			end else if (!halt_granted) begin
				// a halt that cannot be taken yet is only recorded, never forced
				if (halt_ok) begin
					halt_granted <= 1'b1;
					halt_pending <= 1'b0;
				end else begin
					halt_pending <= 1'b1;
				end
			end
		end
	end

endmodule
`default_nettype wire

// file: dbsr_defines.vh
// constants for the shared-bus dma engine: register offsets, fields, reset values, timing
`ifndef DBSR_DEFINES_VH
`define DBSR_DEFINES_VH

// ----------------------------------------
// register offsets (word index on the plain port)
// ----------------------------------------
`define DBSR_REG_CTRL      4'h0
`define DBSR_REG_SRC_LO    4'h1
`define DBSR_REG_SRC_HI    4'h2
`define DBSR_REG_DST_LO    4'h3
`define DBSR_REG_DST_HI    4'h4
`define DBSR_REG_SIZE      4'h5
`define DBSR_REG_STATUS    4'h6
`define DBSR_REG_SRC_WORD  4'h7
`define DBSR_REG_DST_WORD  4'h8

// ----------------------------------------
// control field positions
// ----------------------------------------
`define DBSR_CTRL_EN       0
`define DBSR_CTRL_REPEAT   1
`define DBSR_CTRL_BURST    2
`define DBSR_CTRL_RMWDIS   3
`define DBSR_CTRL_START    4

// ----------------------------------------
// reset values
// ----------------------------------------
`define DBSR_CTRL_RST      5'h00
`define DBSR_ADDR_RST      20'h0_0000
`define DBSR_SIZE_RST      16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define DBSR_RELEASE_CYC   2'h3
`define DBSR_BURST_WIN     4'ha
`define DBSR_BURST_DMA     4'h8

`endif

// file: dbsr_engine_sva.sv
// port assertions for the shared-bus dma engine
`timescale 1ns/1ps
`default_nettype none
module dbsr_engine_sva (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        resetn,
	// register port
	input wire logic [3:0]  reg_addr,
	input wire logic [19:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [19:0] reg_rdata,
	// shared bus and halt
	input wire logic        cpu_bus_req,
	input wire logic        cpu_rmw_active,
	input wire logic        bus_wait,
	input wire logic        dma_bus_req,
	input wire logic        bus_valid,
	input wire logic        bus_write,
	input wire logic [19:0] bus_addr,
	input wire logic        halt_request,
	input wire logic        halt_granted,
	input wire logic        halt_pending,
	input wire logic        xfer_done
);
	// mode bits mirrored from control writes, the ports do not show them
	logic [3:0] ctl;
	always @(posedge core_clk or negedge resetn)
		if (!resetn)
			ctl <= 4'h0;
		else if (reg_wr && reg_addr == 4'h0)
			ctl <= reg_wdata[3:0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	chk_grant_free:
	assert property ($rose(halt_granted) |-> $past(!dma_bus_req && !cpu_bus_req))
		else $error("halt granted on busy bus");
	chk_halt_waits:
	assert property (halt_request && !halt_granted && (dma_bus_req || cpu_bus_req)
		|=> halt_pending) else $error("halt not pending");
	chk_halt_still:
	assert property (halt_granted |-> !bus_valid) else $error("move while halted");
	chk_release_req:
	assert property (xfer_done && !ctl[1] |-> ##[0:3] !dma_bus_req)
		else $error("bus request held");
	chk_rmw_defer:
	assert property ($rose(bus_valid) |-> !$past(ctl[3] && cpu_rmw_active))
		else $error("move inside rmw");
	chk_burst_share:
	assert property (ctl[2] && $fell(bus_valid) && !xfer_done && dma_bus_req
		|-> ##[1:10] $rose(bus_valid)) else $error("burst unit late");
	chk_wait_hold:
	assert property (bus_valid && bus_wait |=> bus_valid && $stable(bus_addr))
		else $error("bus cycle moved in wait");
	chk_rdata_idle:
	assert property (!$past(reg_rd) |-> reg_rdata == 20'h0_0000)
		else $error("read data not idle");
	cover property (xfer_done && ctl[1]);
	cover property ($rose(halt_granted));
	cover property (halt_pending && cpu_bus_req);
endmodule
`default_nettype wire

// file: dbsr_bus_model.sv
// far side of the shared bus: slave with wait states and a cpu request
`timescale 1ns/1ps
`default_nettype none
module dbsr_bus_model (
	// clock and bench commands
	input wire logic         core_clk,
	input wire logic         slow,
	input wire logic         cpu_want,
	// engine bus
	input wire logic         bus_valid,
	input wire logic         bus_write,
	input wire logic [19:0]  bus_addr,
	// answers
	output logic             bus_wait,
	output wire logic [15:0] bus_rdata,
	output logic             cpu_bus_req
);
	logic [15:0] last = 16'h0000;
	// outside a read the data keep changing so a late sample shows
	assign bus_rdata = (bus_valid && !bus_write) ? bus_addr[15:0] ^ 16'ha5a5 : last;
	initial bus_wait = 1'b0;
	initial cpu_bus_req = 1'b0;
	always @(posedge core_clk) begin
		bus_wait <= slow & ~bus_wait;
		cpu_bus_req <= cpu_want;
		last <= ~bus_rdata;
	end
endmodule
`default_nettype wire

// file: dbsr_engine_bench.sv
// self-checking bench for the shared-bus dma engine
`timescale 1ns/1ps
`default_nettype none
`include "dbsr_defines.vh"
module dbsr_engine_bench;
	logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, dma_trigger = 0;
	logic cpu_rmw_active = 0, halt_request = 0, slow = 0, cpu_want = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [19:0] reg_wdata = 20'h0_0000, src, dst;
	wire [19:0] reg_rdata, bus_addr;
	wire [15:0] bus_rdata, bus_wdata;
	wire cpu_bus_req, bus_wait, dma_bus_req, bus_valid, bus_write;
	wire halt_granted, halt_pending, xfer_done;
	integer seed = 25233, miscompares = 0, checks = 0, cyc = 0, i, k, c0;
	always #2.5 core_clk = ~core_clk;
	dbsr_engine dut_u (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .dma_trigger, .cpu_bus_req, .cpu_rmw_active, .bus_wait, .dma_bus_req,
		.bus_valid, .bus_write, .bus_addr, .bus_rdata, .bus_wdata, .halt_request,
		.halt_granted, .halt_pending, .xfer_done);
	dbsr_bus_model far_u (.core_clk, .slow, .cpu_want, .bus_valid, .bus_write,
		.bus_addr, .bus_wait, .bus_rdata, .cpu_bus_req);
	task tick;
		@(posedge core_clk);
		#1;
	endtask
	task chk(input [19:0] g, input [19:0] e);
		checks = checks + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task chkb(input g, input e);
		chk({19'h0_0000, g}, {19'h0_0000, e});
	endtask
	task wr(input [3:0] a, input [19:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task rd(input [3:0] a, input [19:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 chk(reg_rdata, e);
	endtask
	// enable is set one write ahead of the start bit
	task go(input [4:0] m, input [15:0] n);
		wr(`DBSR_REG_SIZE, {4'h0, n});
		wr(`DBSR_REG_CTRL, {15'h0_0000, m});
		wr(`DBSR_REG_CTRL, {15'h0_0000, m | 5'h10});
	endtask
	task wbus(input w);
		tick;
		for (k = 0; k < 60 && (bus_valid !== 1 || bus_write !== w); k = k + 1) tick;
	endtask
	task wdone;
		tick;
		for (k = 0; k < 200 && xfer_done !== 1; k = k + 1) tick;
		chkb(xfer_done, 1);
	endtask
	function [19:0] far(input [19:0] a);
		far = {4'h0, a[15:0] ^ 16'ha5a5};
	endfunction
	task results;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			miscompares = miscompares + 1;
			results;
		end
	end
	initial begin
		repeat (12) @(posedge core_clk);
		resetn <= 1;
		rd(`DBSR_REG_SIZE, 20'h0_0000);
		rd(4'hf, 20'h0_0000);
		for (i = 0; i < 3; i = i + 1) begin
			src = 20'($random(seed));
			dst = 20'($random(seed));
			slow <= i[0];
			wr(`DBSR_REG_SRC_LO, src);
			wr(`DBSR_REG_DST_LO, dst);
			go(5'h01, 16'h0001);
			wbus(0);
			chk(bus_addr, src);
			wbus(1);
			chk(bus_addr, dst);
			chk({4'h0, bus_wdata}, far(src));
			wdone;
		end
		$display("test random moves done");
		wr(`DBSR_REG_SRC_WORD, 20'(~src));
		wr(`DBSR_REG_CTRL, 20'h0_0001);
		dma_trigger <= 1;
		wbus(0);
		chk(bus_addr, {4'h0, ~src[15:0]});
		dma_trigger <= 0;
		wdone;
		wr(`DBSR_REG_SRC_LO, src);
		go(5'h03, 16'h0002);
		wdone;
		wbus(0);
		chk(bus_addr, src);
		wr(`DBSR_REG_CTRL, 20'h0_0000);
		repeat (12) tick;
		chkb(dma_bus_req, 0);
		$display("test word and repeat done");
		go(5'h05, 16'h0008);
		halt_request <= 1;
		repeat (4) tick;
		chkb(halt_pending, 1);
		c0 = cyc;
		wdone;
		// eight units, two per ten-cycle window, the last window cut after its write
		chk(20'(cyc - c0), 20'h0_0022);
		repeat (6) tick;
		chkb(halt_granted, 1);
		halt_request <= 0;
		$display("test burst halt done");
		cpu_rmw_active <= 1;
		go(5'h09, 16'h0001);
		repeat (10) tick;
		chkb(bus_valid, 0);
		cpu_rmw_active <= 0;
		wbus(0);
		chk(bus_addr, src);
		wdone;
		$display("test rmw inhibit done");
		cpu_want <= 1;
		halt_request <= 1;
		repeat (3) tick;
		chkb(halt_pending, 1);
		cpu_want <= 0;
		repeat (3) tick;
		chkb(halt_granted, 1);
		$display("test cpu halt done");
		results;
	end
endmodule
bind dbsr_engine dbsr_engine_sva chk_u (.core_clk, .resetn, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .cpu_bus_req, .cpu_rmw_active, .bus_wait, .dma_bus_req,
	.bus_valid, .bus_write, .bus_addr, .halt_request, .halt_granted, .halt_pending, .xfer_done);
`default_nettype wire
